// *** rtl/eve_cfg.svh ***
// Constants of the early-vector exception unit: vectors, field positions.
// Assumes inclusion by bare name from the package; design modules use its macros without including it.
// What this block does
// - Enabled debug causes raise debug_exc.
// - Opcode 0F1h raises debug_exc.
// - No error code; causes go to debug_status_reg.
// - Breakpoint and general detect give a debug fault.
// - Other debug causes trap with the next pointer.
// - resume_flag clears per good instruction, later after return_from_interrupt, jump, call.
// - Non-debug exceptions and interrupted string instructions push resume_flag as 1.
// - With resume_flag set, skip the instruction breakpoint once, then clear it.
// - Delivering debug_exc pushes resume_flag as 0.
// - Take a non-maskable interrupt at a boundary on vector 2, next pointer.
// - After taking one, ignore further non-maskable requests until return_from_interrupt.
// - one_byte_break_instr traps on vector 3, pointer past the byte.
// - Overflow trap with arith_overflow_flag 1 traps on vector 4.
// - Array-limit check outside bounds faults on vector 5 at that instruction.
// - Reserved opcodes, undefined instrs, bad lock, bad operands fault on vector 6.
// - Fast syscall in long mode, legacy opcodes in 64-bit mode fault.
// - Control-bit SIMD, debug-alias, sysmgmt-resume cases fault on vector 6.
// - Coprocessor checks on wait, x87 and media raise vector 7 as a fault.
// - Contributory or page-fault pairs escalate to double_fault_exc, vector 8.
// - Third event during double fault shuts down; exit by NMI, reset, soft startup.
// - Double fault is an abort with error code zero and no restart pointer.
`ifndef EVE_CFG_SVH
`define EVE_CFG_SVH

`define EVE_VEC_DB        8'h01
`define EVE_VEC_NMI       8'h02
`define EVE_VEC_BP        8'h03
`define EVE_VEC_OF        8'h04
`define EVE_VEC_BR        8'h05
`define EVE_VEC_UD        8'h06
`define EVE_VEC_NM        8'h07
`define EVE_VEC_DF        8'h08
`define EVE_VEC_DE        8'h00
`define EVE_VEC_TS        8'h0A
`define EVE_VEC_GP        8'h0D
`define EVE_VEC_PF        8'h0E
`define EVE_VEC_CP        8'h15
`define EVE_VEC_VC        8'h1D
`define EVE_VEC_SX        8'h1E

`define EVE_OPC_SINGLE_BYTE_DEBUG_TRAP_INSTR      8'hF1
`define EVE_OPC_FARCALL   8'h9A
`define EVE_OPC_FARJMP    8'hEA
`define EVE_DR_ALIAS_LO   3'h4
`define EVE_DR_ALIAS_HI   3'h5

`define EVE_GD_BIT        13
`define EVE_ST_INS        0
`define EVE_ST_DATA       1
`define EVE_ST_IO         2
`define EVE_ST_SINGLE_BYTE_DEBUG_TRAP_INSTR       3
`define EVE_ST_BD         13
`define EVE_ST_BS         14
`define EVE_ST_BT         15

`define EVE_ERR_NONE      32'h0000_0000
`define EVE_DBG_ST_RST    16'h0000

`endif

// *** rtl/eve_pkg.sv ***
// Types of the early-vector exception unit.
// Assumes eve_cfg.svh on the include path.
`include "eve_cfg.svh"
package eve_pkg;

	// Delivery state machine, one-hot
	typedef enum logic [3:0] {
		EVE_IDLE  = 4'h1,
		EVE_DELIV = 4'h2,
		EVE_DFLT  = 4'h4,
		EVE_SHUT  = 4'h8
	} eve_state_e;

	// How the exception restarts
	typedef enum logic [1:0] {
		EVE_FAULT = 2'h0,
		EVE_TRAP  = 2'h1,
		EVE_ABORT = 2'h2,
		EVE_INTR  = 2'h3
	} eve_kind_e;

	// Class for double-fault escalation
	typedef enum logic [1:0] {
		EVE_BENIGN  = 2'h0,
		EVE_CONTRIB = 2'h1,
		EVE_PGFLT   = 2'h2
	} eve_class_e;

	// Classify a vector; page faults are listed apart
	function automatic eve_class_e eve_class(input logic [7:0] vec);
		eve_class_e c;
		c = EVE_BENIGN;
		if (vec == `EVE_VEC_PF) begin
			c = EVE_PGFLT;
		end else if (vec == `EVE_VEC_DE || (vec >= `EVE_VEC_TS && vec <= `EVE_VEC_GP) ||
			vec == `EVE_VEC_CP || vec == `EVE_VEC_VC || vec == `EVE_VEC_SX) begin
			c = EVE_CONTRIB;
		end
		return c;
	endfunction

endpackage

// *** rtl/eve_dbg_detect.sv ***
// Debug-event detection: splits causes into fault and trap classes.
// Assumes same-clock event strobes from the address comparators.
`timescale 1ns/1ps
module eve_dbg_detect
	import eve_pkg::*;
(
	// Enables
	input  wire logic        i_dbg_en,
	input  wire logic        i_gd,
	input  wire logic        i_rf,
	input  wire logic        i_tf,
	// Events of the current instruction
	input  wire logic        i_ins_match,
	input  wire logic        i_data_rd,
	input  wire logic        i_data_wr,
	input  wire logic        i_io_rd,
	input  wire logic        i_io_wr,
	input  wire logic        i_task_sw,
	input  wire logic        i_dr_access,
	input  wire logic [7:0]  i_opcode,
	// Results
	output logic             o_fault,
	output logic             o_trap,
	output logic [15:0]      o_cause
);
	logic ins_hit;
	logic gd_hit;
	logic single_byte_debug_trap_instr_hit;

	// Breakpoint masked once by the resume flag
	assign ins_hit  = i_dbg_en & i_ins_match & ~i_rf;
	assign gd_hit   = i_dbg_en & i_dr_access & i_gd;
	assign single_byte_debug_trap_instr_hit = (i_opcode == `EVE_OPC_SINGLE_BYTE_DEBUG_TRAP_INSTR);
	assign o_fault  = ins_hit | gd_hit;
	assign o_trap   = single_byte_debug_trap_instr_hit | (i_dbg_en & (i_tf | i_data_rd | i_data_wr |
		i_io_rd | i_io_wr | i_task_sw));

	// Cause bits for the status register
	always_comb begin
		o_cause                = `EVE_DBG_ST_RST;
		o_cause[`EVE_ST_INS]   = ins_hit;
		o_cause[`EVE_ST_DATA]  = i_dbg_en & (i_data_rd | i_data_wr);
		o_cause[`EVE_ST_IO]    = i_dbg_en & (i_io_rd | i_io_wr);
		o_cause[`EVE_ST_SINGLE_BYTE_DEBUG_TRAP_INSTR]  = single_byte_debug_trap_instr_hit;
		o_cause[`EVE_ST_BD]    = gd_hit;
		o_cause[`EVE_ST_BS]    = i_dbg_en & i_tf;
		o_cause[`EVE_ST_BT]    = i_dbg_en & i_task_sw;
	end
endmodule

// *** rtl/eve_ud_classify.sv ***
// Invalid-opcode and coprocessor-unavailable decode for one instruction.
// Assumes decode attributes and control bits from the same clock.
`timescale 1ns/1ps
module eve_ud_classify
	import eve_pkg::*;
(
	// Decode attributes
	input  wire logic        i_reserved_op,
	input  wire logic        i_undef_instr,
	input  wire logic        i_lock,
	input  wire logic        i_lockable,
	input  wire logic        i_mem_target,
	input  wire logic        i_bad_operand,
	input  wire logic        i_fast_syscall,
	input  wire logic        i_legacy64,
	input  wire logic [7:0]  i_opcode,
	input  wire logic        i_legacy_simd,
	input  wire logic        i_simd,
	input  wire logic        i_media,
	input  wire logic        i_simd_num_exc,
	input  wire logic        i_dr_access,
	input  wire logic [2:0]  i_dr_index,
	input  wire logic        i_sysmgmt_resume,
	input  wire logic        i_x87,
	input  wire logic        i_fpu_wait,
	// Mode and control bits
	input  wire logic        i_long_mode,
	input  wire logic        i_mode64,
	input  wire logic        i_in_sysmgmt,
	input  wire logic        i_ext_save_en,
	input  wire logic        i_simd_fault_en,
	input  wire logic        i_softsim,
	input  wire logic        i_dbg_ext,
	input  wire logic        i_monitor,
	input  wire logic        i_task_sw_bit,
	// Results
	output logic             o_ud,
	output logic             o_nm
);
	logic ud_base;
	logic ud_mode;
	logic ud_ctl;
	logic alias_dr;

	assign ud_base  = i_reserved_op | i_undef_instr | i_bad_operand |
		(i_lock & (~i_lockable | ~i_mem_target));
	assign ud_mode  = (i_fast_syscall & i_long_mode) | (i_mode64 & (i_legacy64 |
		i_opcode == `EVE_OPC_FARCALL | i_opcode == `EVE_OPC_FARJMP));
	assign alias_dr = i_dr_index == `EVE_DR_ALIAS_LO | i_dr_index == `EVE_DR_ALIAS_HI;
	assign ud_ctl   = (i_legacy_simd & ~i_ext_save_en) | ((i_simd | i_media) & i_softsim) |
		(i_simd_num_exc & ~i_simd_fault_en) | (i_dr_access & alias_dr & i_dbg_ext) |
		(i_sysmgmt_resume & ~i_in_sysmgmt);
	assign o_ud     = ud_base | ud_mode | ud_ctl;
	// Wait faults only with monitor and task-switched
	assign o_nm     = (i_fpu_wait & i_monitor & i_task_sw_bit) | (i_x87 & i_softsim) |
		((i_x87 | i_simd | i_media) & i_task_sw_bit);
endmodule

// *** rtl/eve_exc_unit.sv ***
// Exception selection and delivery for vectors 1 to 8 with escalation.
// Assumes one retire strobe per instruction and a dispatcher that
// acknowledges each delivered exception with a done pulse.
`timescale 1ns/1ps
module eve_exc_unit
	import eve_pkg::*;
#(
	parameter int IP_W = 64
)(
	// Clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	// Retiring instruction
	input  wire logic            i_instr_valid,
	input  wire logic [IP_W-1:0] i_ip,
	input  wire logic [IP_W-1:0] i_next_ip,
	input  wire logic [7:0]      i_opcode,
	input  wire logic            i_one_byte_break_instr,
	input  wire logic            i_ovf_trap_instr,
	input  wire logic            i_bound_instr,
	input  wire logic [31:0]     i_bound_index,
	input  wire logic [31:0]     i_bound_lo,
	input  wire logic [31:0]     i_bound_hi,
	input  wire logic            i_return_from_interrupt,
	input  wire logic            i_rf_defer_instr,
	input  wire logic            i_string_instr,
	input  wire logic            i_popped_rf,
	// Decode attributes
	input  wire logic            i_reserved_op,
	input  wire logic            i_reserved_undefined_instrs,
	input  wire logic            i_lock,
	input  wire logic            i_lockable,
	input  wire logic            i_mem_target,
	input  wire logic            i_bad_operand,
	input  wire logic            i_fast_syscall_entry_exit,
	input  wire logic            i_legacy64,
	input  wire logic            i_legacy_simd,
	input  wire logic            i_simd,
	input  wire logic            i_media,
	input  wire logic            i_simd_num_exc,
	input  wire logic            i_dr_access,
	input  wire logic [2:0]      i_dr_index,
	input  wire logic            i_resume_from_sysmgmt,
	input  wire logic            i_x87,
	input  wire logic            i_fpu_wait_instr,
	// Debug comparators
	input  wire logic            i_dbg_ins_match,
	input  wire logic            i_dbg_data_rd,
	input  wire logic            i_dbg_data_wr,
	input  wire logic            i_dbg_io_rd,
	input  wire logic            i_dbg_io_wr,
	input  wire logic            i_dbg_task_sw,
	input  wire logic            i_dbg_status_clr,
	// Mode and control bits
	input  wire logic            i_dbg_en,
	input  wire logic [31:0]     i_debug_control_reg,
	input  wire logic            i_single_step_flag,
	input  wire logic            i_arith_overflow_flag,
	input  wire logic            i_long_mode,
	input  wire logic            i_mode64,
	input  wire logic            i_system_management_mode,
	input  wire logic            i_extended_state_save_enable,
	input  wire logic            i_simd_fault_enable,
	input  wire logic            i_fpu_softsim_bit,
	input  wire logic            i_dbg_ext_bit,
	input  wire logic            i_monitor_coproc_bit,
	input  wire logic            i_task_switched_bit,
	// NMI pin and soft startup
	input  wire logic            i_nmi,
	input  wire logic            i_soft_startup,
	// Other vectors and delivery
	input  wire logic            i_other_exc_valid,
	input  wire logic [7:0]      i_other_exc_vector,
	input  wire logic            i_other_exc_has_err,
	input  wire logic [31:0]     i_other_exc_err_code,
	input  wire logic            i_deliver_done,
	// Exception to dispatch
	output logic                 o_exc_valid,
	output logic [7:0]           o_exc_vector,
	output logic                 o_exc_has_err,
	output logic [31:0]          o_exc_err_code,
	output eve_kind_e            o_exc_kind,
	output logic [IP_W-1:0]      o_saved_ip,
	output logic                 o_pushed_rf,
	// Status
	output logic                 o_resume_flag,
	output logic [15:0]          o_debug_status_reg,
	output logic                 o_nmi_blocked,
	output logic                 o_shutdown
);
	// Narrow pointers cannot hold code addresses
	initial begin
		if (IP_W < 16 || IP_W > 64) begin
			$error("eve_exc_unit: IP_W out of range");
		end
	end

	typedef struct packed {
		eve_state_e      state;
		logic            nmi_s1;
		logic            nmi_s2;
		logic            nmi_s3;
		logic            nmi_pend;
		logic            nmi_blk;
		logic            rf;
		logic [7:0]      cur_vec;
		logic            exc_valid;
		logic [7:0]      exc_vec;
		logic            exc_err;
		logic [31:0]     err_code;
		eve_kind_e       kind;
		logic [IP_W-1:0] saved_ip;
		logic            pushed_rf;
		logic [15:0]     dbg_st;
	} eve_st_s;

	eve_st_s st;
	eve_st_s next_st;

	logic        dbg_fault;
	logic        dbg_trap;
	logic [15:0] dbg_cause;
	logic        ud_hit;
	logic        nm_hit;
	logic        br_hit;
	logic        of_hit;
	logic        nmi_edge;
	logic        df_pair;
	eve_class_e  cur_cls;
	eve_class_e  new_cls;

	// Debug causes
	eve_dbg_detect u_dbg (
		.i_dbg_en    (i_dbg_en),
		.i_gd        (i_debug_control_reg[`EVE_GD_BIT]),
		.i_rf        (st.rf),
		.i_tf        (i_single_step_flag),
		.i_ins_match (i_dbg_ins_match),
		.i_data_rd   (i_dbg_data_rd),
		.i_data_wr   (i_dbg_data_wr),
		.i_io_rd     (i_dbg_io_rd),
		.i_io_wr     (i_dbg_io_wr),
		.i_task_sw   (i_dbg_task_sw),
		.i_dr_access (i_dr_access),
		.i_opcode    (i_opcode),
		.o_fault     (dbg_fault),
		.o_trap      (dbg_trap),
		.o_cause     (dbg_cause)
	);

	// Invalid-opcode and coprocessor checks
	eve_ud_classify u_ud (
		.i_reserved_op    (i_reserved_op),
		.i_undef_instr    (i_reserved_undefined_instrs),
		.i_lock           (i_lock),
		.i_lockable       (i_lockable),
		.i_mem_target     (i_mem_target),
		.i_bad_operand    (i_bad_operand),
		.i_fast_syscall   (i_fast_syscall_entry_exit),
		.i_legacy64       (i_legacy64),
		.i_opcode         (i_opcode),
		.i_legacy_simd    (i_legacy_simd),
		.i_simd           (i_simd),
		.i_media          (i_media),
		.i_simd_num_exc   (i_simd_num_exc),
		.i_dr_access      (i_dr_access),
		.i_dr_index       (i_dr_index),
		.i_sysmgmt_resume (i_resume_from_sysmgmt),
		.i_x87            (i_x87),
		.i_fpu_wait       (i_fpu_wait_instr),
		.i_long_mode      (i_long_mode),
		.i_mode64         (i_mode64),
		.i_in_sysmgmt     (i_system_management_mode),
		.i_ext_save_en    (i_extended_state_save_enable),
		.i_simd_fault_en  (i_simd_fault_enable),
		.i_softsim        (i_fpu_softsim_bit),
		.i_dbg_ext        (i_dbg_ext_bit),
		.i_monitor        (i_monitor_coproc_bit),
		.i_task_sw_bit    (i_task_switched_bit),
		.o_ud             (ud_hit),
		.o_nm             (nm_hit)
	);

	// Bound and overflow checks
	assign br_hit   = i_bound_instr & (($signed(i_bound_index) < $signed(i_bound_lo)) |
		($signed(i_bound_index) > $signed(i_bound_hi)));
	assign of_hit   = i_ovf_trap_instr & i_arith_overflow_flag;
	// Edge past the second sync stage
	assign nmi_edge = st.nmi_s2 & ~st.nmi_s3;
	// Escalation pair check
	assign cur_cls  = eve_class(st.cur_vec);
	assign new_cls  = eve_class(i_other_exc_vector);
	assign df_pair  = (cur_cls == EVE_CONTRIB && new_cls == EVE_CONTRIB) ||
		(cur_cls == EVE_PGFLT && new_cls != EVE_BENIGN);

	// Next state
	always_comb begin
		next_st           = st;
		next_st.exc_valid = 1'b0;
		next_st.nmi_s1    = i_nmi;
		next_st.nmi_s2    = st.nmi_s1;
		next_st.nmi_s3    = st.nmi_s2;
		// Requests while blocked are dropped, not queued
		if (nmi_edge && !st.nmi_blk) begin
			next_st.nmi_pend = 1'b1;
		end
		// Sticky causes; set beats clear
		if (i_dbg_status_clr) begin
			next_st.dbg_st = `EVE_DBG_ST_RST;
		end
		case (st.state)
			EVE_IDLE: begin
				if (i_other_exc_valid) begin
					next_st.exc_valid = 1'b1;
					next_st.exc_vec   = i_other_exc_vector;
					next_st.exc_err   = i_other_exc_has_err;
					next_st.err_code  = i_other_exc_err_code;
					next_st.kind      = EVE_FAULT;
					next_st.saved_ip  = i_ip;
					next_st.pushed_rf = 1'b1;
					next_st.cur_vec   = i_other_exc_vector;
					next_st.state     = EVE_DELIV;
				end else if (i_instr_valid) begin
					next_st.exc_err   = 1'b0;
					next_st.err_code  = `EVE_ERR_NONE;
					next_st.saved_ip  = i_ip;
					next_st.kind      = EVE_FAULT;
					next_st.pushed_rf = 1'b1;
					next_st.exc_valid = 1'b1;
					// Faults first
					if (dbg_fault) begin
						next_st.exc_vec   = `EVE_VEC_DB;
						next_st.pushed_rf = 1'b0;
						next_st.dbg_st    = (i_dbg_status_clr ? `EVE_DBG_ST_RST : st.dbg_st) |
							dbg_cause;
					end else if (ud_hit) begin
						next_st.exc_vec   = `EVE_VEC_UD;
					end else if (nm_hit) begin
						next_st.exc_vec   = `EVE_VEC_NM;
					end else if (br_hit) begin
						next_st.exc_vec   = `EVE_VEC_BR;
					end else begin
						// Completed: resume flag
						if (i_return_from_interrupt) begin
							next_st.rf      = i_popped_rf;
							next_st.nmi_blk = 1'b0;
						end else if (!i_rf_defer_instr) begin
							next_st.rf      = 1'b0;
						end
						next_st.saved_ip = i_next_ip;
						next_st.kind     = EVE_TRAP;
						if (dbg_trap) begin
							next_st.exc_vec   = `EVE_VEC_DB;
							next_st.pushed_rf = 1'b0;
							next_st.dbg_st    = (i_dbg_status_clr ? `EVE_DBG_ST_RST :
								st.dbg_st) | dbg_cause;
						end else if (i_one_byte_break_instr) begin
							next_st.exc_vec   = `EVE_VEC_BP;
						end else if (of_hit) begin
							next_st.exc_vec   = `EVE_VEC_OF;
						end else if (st.nmi_pend && !st.nmi_blk) begin
							// Only at a boundary
							next_st.exc_vec   = `EVE_VEC_NMI;
							next_st.kind      = EVE_INTR;
							next_st.pushed_rf = i_string_instr;
							next_st.nmi_pend  = 1'b0;
							next_st.nmi_blk   = 1'b1;
						end else begin
							next_st.exc_valid = 1'b0;
						end
					end
					next_st.cur_vec = next_st.exc_vec;
					if (next_st.exc_valid) begin
						next_st.state = EVE_DELIV;
					end
				end
			end
			EVE_DELIV: begin
				if (i_other_exc_valid && df_pair) begin
					next_st.exc_valid = 1'b1;
					next_st.exc_vec   = `EVE_VEC_DF;
					next_st.exc_err   = 1'b1;
					next_st.err_code  = `EVE_ERR_NONE;
					next_st.kind      = EVE_ABORT;
					next_st.saved_ip  = '0;
					next_st.pushed_rf = 1'b1;
					next_st.cur_vec   = `EVE_VEC_DF;
					next_st.state     = EVE_DFLT;
				end else if (i_other_exc_valid) begin
					// Benign pair: second in turn
					next_st.exc_valid = 1'b1;
					next_st.exc_vec   = i_other_exc_vector;
					next_st.exc_err   = i_other_exc_has_err;
					next_st.err_code  = i_other_exc_err_code;
					next_st.kind      = EVE_FAULT;
					next_st.pushed_rf = 1'b1;
					next_st.cur_vec   = i_other_exc_vector;
				end else if (i_deliver_done) begin
					next_st.state = EVE_IDLE;
				end
			end
			EVE_DFLT: begin
				if (i_other_exc_valid) begin
					next_st.state = EVE_SHUT;
				end else if (i_deliver_done) begin
					next_st.state = EVE_IDLE;
				end
			end
			EVE_SHUT: begin
				// In an NMI handler only reset or soft startup wakes it
				if (nmi_edge && !st.nmi_blk) begin
					next_st.exc_valid = 1'b1;
					next_st.exc_vec   = `EVE_VEC_NMI;
					next_st.exc_err   = 1'b0;
					next_st.err_code  = `EVE_ERR_NONE;
					next_st.kind      = EVE_INTR;
					next_st.saved_ip  = '0;
					next_st.pushed_rf = 1'b0;
					next_st.nmi_pend  = 1'b0;
					next_st.nmi_blk   = 1'b1;
					next_st.cur_vec   = `EVE_VEC_NMI;
					next_st.state     = EVE_DELIV;
				end
			end
			default: begin
				next_st.state = EVE_IDLE;
			end
		endcase
		// Soft startup restarts from any state
		if (i_soft_startup) begin
			next_st.state     = EVE_IDLE;
			next_st.exc_valid = 1'b0;
			next_st.nmi_pend  = 1'b0;
			next_st.nmi_blk   = 1'b0;
			next_st.rf        = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st        <= '0;
			st.state  <= EVE_IDLE;
			st.kind   <= EVE_FAULT;
			st.dbg_st <= `EVE_DBG_ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// Outputs from the state register
	assign o_exc_valid        = st.exc_valid;
	assign o_exc_vector       = st.exc_vec;
	assign o_exc_has_err      = st.exc_err;
	assign o_exc_err_code     = st.err_code;
	assign o_exc_kind         = st.kind;
	assign o_saved_ip         = st.saved_ip;
	assign o_pushed_rf        = st.pushed_rf;
	assign o_resume_flag      = st.rf;
	assign o_debug_status_reg = st.dbg_st;
	assign o_nmi_blocked      = st.nmi_blk;
	assign o_shutdown         = st.state == EVE_SHUT;
endmodule

// *** verification/eve_exc_chk.sv ***
// Checker of the early-vector exception unit ports.
// Assumes the bind at the foot onto eve_exc_unit.
`timescale 1ns/1ps
module eve_exc_chk
	import eve_pkg::*;
#(
	parameter int IP_W = 64
)(
	// Clock, reset, requests
	input wire logic            i_clk,
	input wire logic            i_rst_n,
	input wire logic            i_instr_valid,
	input wire logic            i_other_exc_valid,
	input wire logic [IP_W-1:0] i_ip,
	input wire logic [IP_W-1:0] i_next_ip,
	// Presented exception
	input wire logic            o_exc_valid,
	input wire logic [7:0]      o_exc_vector,
	input wire logic            o_exc_has_err,
	input wire logic [31:0]     o_exc_err_code,
	input wire eve_kind_e       o_exc_kind,
	input wire logic [IP_W-1:0] o_saved_ip,
	input wire logic            o_pushed_rf,
	input wire logic            o_nmi_blocked,
	input wire logic            o_shutdown
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Vector v shown; third event after a double fault
	sequence s_exc(v);
		o_exc_valid && o_exc_vector == v;
	endsequence
	sequence s_third;
		s_exc(8'h08) ##1 i_other_exc_valid;
	endsequence
	AST_DF_ABORT:
		assert property (s_exc(8'h08) |-> o_exc_kind == EVE_ABORT && o_exc_has_err
			&& o_exc_err_code == 32'h0 && o_saved_ip == '0) else $error("double fault fields");
	AST_NO_ERR:
		assert property (o_exc_valid && o_exc_vector inside {[8'h01:8'h07]} |-> !o_exc_has_err)
			else $error("error flag on early vector");
	AST_DB_RF:
		assert property (s_exc(8'h01) |-> !o_pushed_rf) else $error("debug pushed rf set");
	AST_OTH_RF:
		assert property (o_exc_valid && o_exc_vector inside {[8'h03:8'h07]} |-> o_pushed_rf)
			else $error("pushed rf clear");
	AST_TRAP:
		assert property (o_exc_valid && o_exc_vector inside {8'h03, 8'h04}
			|-> o_exc_kind == EVE_TRAP && o_saved_ip == $past(i_next_ip))
			else $error("trap pointer wrong");
	AST_FAULT:
		assert property (o_exc_valid && o_exc_vector inside {[8'h05:8'h07]}
			|-> o_exc_kind == EVE_FAULT && o_saved_ip == $past(i_ip))
			else $error("fault pointer wrong");
	AST_NMI:
		assert property (s_exc(8'h02) ##0 !$past(o_shutdown) |-> o_exc_kind == EVE_INTR
			&& o_nmi_blocked && o_saved_ip == $past(i_next_ip)) else $error("nmi fields");
	AST_THIRD:
		assert property (s_third |=> o_shutdown) else $error("no shutdown");
	AST_PULSE:
		assert property (o_exc_valid && !i_other_exc_valid |=> !o_exc_valid)
			else $error("valid longer than a cycle");
	AST_QUIET:
		assert property (o_shutdown && i_instr_valid |=> !o_exc_valid)
			else $error("retire seen in shutdown");
endmodule
bind eve_exc_unit eve_exc_chk #(.IP_W(IP_W)) u_eve_exc_chk (.*);

// *** verification/eve_dispatch_model.sv ***
// Dispatch-side model: acknowledges the most recently presented exception.
// Assumes the unit's clock; i_slow stretches the reply.
`timescale 1ns/1ps
module eve_dispatch_model (
	// Clock, reset, speed
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_slow,
	// Handshake
	input  wire logic i_exc,
	output logic      o_done
);
	logic [3:0] cnt;
	// A new exception restarts the wait
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 4'h0;
			o_done <= 1'b0;
		end else begin
			o_done <= (cnt == 4'h1);
			cnt <= i_exc ? (i_slow ? 4'h8 : 4'h2) : cnt - {3'h0, cnt != 4'h0};
		end
	end
endmodule

// *** verification/early_vector_exception_logic_bench.sv ***
// Bench of the early-vector exception unit, one task a scenario.
// Assumes the unit, checker and dispatch model compiled first.
`timescale 1ns/1ps
module early_vector_exception_logic_bench
	import eve_pkg::*;
;
	// Inputs but i_ip and i_next_ip start at 0, so reset is held low
	bit i_clk, i_rst_n, i_slow, i_instr_valid, i_one_byte_break_instr, i_ovf_trap_instr,
		i_bound_instr, i_return_from_interrupt, i_rf_defer_instr, i_string_instr, i_popped_rf,
		i_reserved_op, i_reserved_undefined_instrs, i_lock, i_lockable, i_mem_target,
		i_bad_operand, i_fast_syscall_entry_exit, i_legacy64, i_legacy_simd, i_simd, i_media,
		i_simd_num_exc, i_dr_access, i_resume_from_sysmgmt, i_x87, i_fpu_wait_instr,
		i_dbg_ins_match, i_dbg_data_rd, i_dbg_data_wr, i_dbg_io_rd, i_dbg_io_wr, i_dbg_task_sw,
		i_dbg_status_clr, i_dbg_en, i_single_step_flag, i_arith_overflow_flag, i_long_mode,
		i_mode64, i_system_management_mode, i_extended_state_save_enable, i_simd_fault_enable,
		i_fpu_softsim_bit, i_dbg_ext_bit, i_monitor_coproc_bit, i_task_switched_bit, i_nmi,
		i_soft_startup, i_other_exc_valid, i_other_exc_has_err;
	bit [2:0] i_dr_index;
	bit [7:0] i_opcode, i_other_exc_vector;
	bit [31:0] i_bound_index, i_bound_lo, i_bound_hi, i_debug_control_reg, i_other_exc_err_code;
	bit [63:0] i_ip = 64'h1000, i_next_ip = 64'h1001;
	logic i_deliver_done, o_exc_valid, o_exc_has_err, o_pushed_rf, o_resume_flag, o_nmi_blocked;
	logic o_shutdown;
	logic [7:0] o_exc_vector;
	logic [15:0] o_debug_status_reg;
	logic [31:0] o_exc_err_code;
	logic [63:0] o_saved_ip;
	eve_kind_e o_exc_kind;
	int n_errors, samples_checked;

	eve_exc_unit u_eve_exc_unit (.*);
	eve_dispatch_model u_eve_dispatch_model (.i_clk, .i_rst_n, .i_slow, .i_exc(o_exc_valid),
		.o_done(i_deliver_done));

	// 25 ns clock
	always #12.5 i_clk = ~i_clk;

	task automatic chk(input logic [63:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// One retire; vector FF means none due
	task automatic run(input logic [7:0] v, input eve_kind_e k, input logic [63:0] ip);
		int n;
		@(posedge i_clk); #2 i_instr_valid = 1'b1;
		@(posedge i_clk); #2 i_instr_valid = 1'b0;
		chk(o_exc_valid, v != 8'hFF);
		if (v != 8'hFF) begin
			chk({o_exc_vector, o_exc_kind, o_saved_ip[31:0]}, {v, k, ip[31:0]});
			for (n = 0; n < 20 && !i_deliver_done; n++) @(posedge i_clk) #1;
			if (n == 20) begin
				n_errors++;
				close_out();
			end
		end
		#2;
	endtask

	task automatic oth(input logic [7:0] v);
		@(posedge i_clk); #2 {i_other_exc_valid, i_other_exc_vector} = {1'b1, v};
		@(posedge i_clk); #2 i_other_exc_valid = 1'b0;
	endtask

	task automatic t_traps();
		i_one_byte_break_instr = 1'b1;
		run(8'h03, EVE_TRAP, 64'h1001);
		{i_one_byte_break_instr, i_ovf_trap_instr} = 2'b01;
		run(8'hFF, EVE_TRAP, 0);
		i_arith_overflow_flag = 1'b1;
		run(8'h04, EVE_TRAP, 64'h1001);
		{i_ovf_trap_instr, i_bound_instr, i_bound_index, i_bound_hi} = {2'b01, 32'h5, 32'h5};
		run(8'hFF, EVE_FAULT, 0);
		i_bound_index = 32'hFFFF_FFFF;
		run(8'h05, EVE_FAULT, 64'h1000);
		i_bound_instr = 1'b0;
	endtask

	task automatic t_ud();
		i_reserved_op = 1'b1;
		run(8'h06, EVE_FAULT, 64'h1000);
		{i_reserved_op, i_mode64, i_legacy64, i_opcode} = {3'b011, 8'h9A};
		run(8'h06, EVE_FAULT, 64'h1000);
		{i_mode64, i_legacy64, i_simd, i_fpu_softsim_bit} = 4'h3;
		run(8'h06, EVE_FAULT, 64'h1000);
		{i_simd, i_x87} = 2'b01;
		run(8'h07, EVE_FAULT, 64'h1000);
		{i_x87, i_fpu_softsim_bit, i_fpu_wait_instr, i_monitor_coproc_bit, i_task_switched_bit} = 5'h07;
		run(8'h07, EVE_FAULT, 64'h1000);
		{i_fpu_wait_instr, i_monitor_coproc_bit, i_task_switched_bit} = 3'b101;
		run(8'hFF, EVE_FAULT, 0);
		{i_fpu_wait_instr, i_task_switched_bit} = 2'b00;
	endtask

	task automatic t_dbg();
		i_opcode = 8'hF1;
		run(8'h01, EVE_TRAP, 64'h1001);
		chk(o_debug_status_reg[3], 1'b1);
		{i_opcode, i_dbg_ins_match} = 9'h001;
		run(8'hFF, EVE_FAULT, 0);
		i_dbg_en = 1'b1;
		run(8'h01, EVE_FAULT, 64'h1000);
		{i_return_from_interrupt, i_popped_rf, i_dbg_ins_match} = 3'b110;
		run(8'hFF, EVE_FAULT, 0);
		chk(o_resume_flag, 1'b1);
		{i_return_from_interrupt, i_popped_rf, i_dbg_ins_match} = 3'b001;
		run(8'hFF, EVE_FAULT, 0);
		chk(o_resume_flag, 1'b0);
		{i_dbg_ins_match, i_dbg_data_wr} = 2'b01;
		run(8'h01, EVE_TRAP, 64'h1001);
		i_dbg_data_wr = 1'b0;
	endtask

	task automatic t_nmi();
		i_nmi = 1'b1;
		repeat (4) @(posedge i_clk);
		#2 run(8'h02, EVE_INTR, 64'h1001);
		chk(o_nmi_blocked, 1'b1);
		i_nmi = 1'b0;
		repeat (3) @(posedge i_clk);
		#2 i_nmi = 1'b1;
		repeat (4) @(posedge i_clk);
		#2 run(8'hFF, EVE_FAULT, 0);
		i_return_from_interrupt = 1'b1;
		run(8'hFF, EVE_FAULT, 0);
		chk(o_nmi_blocked, 1'b0);
		{i_return_from_interrupt, i_nmi} = 2'b00;
	endtask

	task automatic t_df();
		i_slow = 1'b1;
		oth(8'h0D);
		chk({o_exc_valid, o_exc_vector}, 9'h10D);
		oth(8'h0D);
		chk({o_exc_valid, o_exc_vector, o_exc_kind}, {9'h108, EVE_ABORT});
		oth(8'h0E);
		chk(o_shutdown, 1'b1);
		run(8'hFF, EVE_FAULT, 0);
		{i_soft_startup, i_slow} = 2'b10;
		@(posedge i_clk); #2 i_soft_startup = 1'b0;
		@(posedge i_clk); #1 chk(o_shutdown, 1'b0);
	endtask

	// Reset, then scenarios
	initial begin
		repeat (16) @(posedge i_clk);
		#2 i_rst_n = 1'b1;
		t_traps();
		t_ud();
		t_dbg();
		t_nmi();
		t_df();
		close_out();
	end
endmodule
